/* File: rtl/switch_line_card.sv */
// line card end: frame timing, flag watch, sync, bulk download, messaging
`timescale 1ns/1ns
`default_nettype none
`include "hs_link_params.svh"

module switch_line_card #(
  parameter int FRAME_CYC = `HS_FRAME_CYC,
  parameter int FLAG_CYC  = `HS_FLAG_CYC,
  parameter int GAP_CYC   = `HS_CARD_GAP_CYC,
  parameter int RETRY_CYC = `HS_RETRY_CYC,
  parameter int DL_LEN    = `HS_DL_LEN
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // loop
  input  wire logic        link_up,
  handshake_link_if.card   lk,
  // commands toward the terminal
  input  wire logic [7:0]  tx_cmd,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  output logic             tx_drop,
  // bulk download content
  output logic [3:0]       dl_idx,
  input  wire logic [7:0]  dl_cmd,
  // messages toward central control
  output logic [15:0]      ctrl_msg,
  output logic             ctrl_valid,
  input  wire logic        ctrl_ready,
  // status
  output logic             term_sync,
  output logic             operational
);

  hs_pkg::card_phase_t ph_q;
  hs_pkg::xmit_t       xs_q;
  hs_pkg::msg_kind_t   kind_q, kind;
  hs_pkg::hs_byte_t    far, out_q;
  logic        restart, frm, frame_q, flag_q, open_q, bulk_q, tsync_q, drop_q;
  logic [23:0] fcnt_q, fl_q, gap_q, age_q;
  logic [1:0]  rxs_q, xi_q, bc_q;
  logic [2:0]  rcnt_q;
  logic [5:0]  pk_q;
  logic [3:0]  dl_q;
  logic [15:0] rmsg_q, xmsg_q, new_msg;
  logic [15:0] bm_q [2];
  logic        bw_q, br_q, pend_q, want, start_new, acked, expired;
  logic        good, ai_sync, is_sync, is_bulk, is_ord, room, take;

  assign restart = srst | ~link_up;
  assign frm     = frame_q;
  assign far     = lk.term_byte;

  // ----------------------------------------------------------------
  // frame timing and flag watch
  // ----------------------------------------------------------------
  // one byte exchange per 1 ms frame
  always_ff @(posedge core_clk) begin
    if (restart) begin
      fcnt_q  <= 24'h0;
      frame_q <= 1'b0;
    end else begin
      frame_q <= fcnt_q == 24'(FRAME_CYC - 1);
      fcnt_q  <= (fcnt_q == 24'(FRAME_CYC - 1)) ? 24'h0 : fcnt_q + 24'h1;
    end
  end

  // flag must stay set and unchanged for the whole interval
  always_ff @(posedge core_clk) begin
    if (restart) begin
      flag_q <= 1'b0;
      fl_q   <= 24'h0;
    end else begin
      flag_q <= lk.term_flag;
      fl_q   <= (lk.term_flag != flag_q || !lk.term_flag) ? 24'h0 : fl_q + 24'h1;
    end
  end

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  assign ai_sync = rmsg_q[15:8] == `HS_AI_SYNC;
  assign is_sync = ai_sync && rmsg_q[7:0] == `HS_CMD_SYNC;
  assign is_bulk = ai_sync && (rmsg_q[7:0] == `HS_CMD_BULK_POS ||
                               rmsg_q[7:0] == `HS_CMD_BULK_NEG);
  assign is_ord  = !ai_sync;
  assign room    = !(is_ord && bc_q == 2'h2);
  assign good    = rcnt_q == `HS_NIBBLES && hs_pkg::cksum(rmsg_q) == far.nib;
  assign take    = frm && far.txs == hs_pkg::TX_REQ_ACK && rxs_q == hs_pkg::RX_CTS &&
                   good && room && open_q;

  // receive state; refusal holds until the terminal goes idle
  always_ff @(posedge core_clk) begin
    if (restart) begin
      rxs_q  <= hs_pkg::RX_CTS;
      rcnt_q <= 3'h0;
    end else if (frm) begin
      unique case (far.txs)
        hs_pkg::TX_IDLE: begin
          rxs_q  <= hs_pkg::RX_CTS;
          rcnt_q <= 3'h0;
        end
        hs_pkg::TX_CHAR: if (rxs_q == hs_pkg::RX_CTS) begin
          if (rcnt_q == `HS_NIBBLES) rxs_q <= hs_pkg::RX_NEG;
          else rcnt_q <= rcnt_q + 3'h1;
        end
        hs_pkg::TX_REQ_ACK: if (rxs_q == hs_pkg::RX_CTS) begin
          rxs_q <= (good && room && open_q) ? hs_pkg::RX_POS : hs_pkg::RX_NEG;
        end
        default: rxs_q <= hs_pkg::RX_NEG;
      endcase
    end
  end

  // nibble assembly
  always_ff @(posedge core_clk) begin
    if (restart) rmsg_q <= 16'h0;
    else if (frm && far.txs == hs_pkg::TX_CHAR && rxs_q == hs_pkg::RX_CTS &&
             rcnt_q != `HS_NIBBLES) rmsg_q <= {rmsg_q[11:0], far.nib};
  end

  // start-up progress seen from the terminal
  always_ff @(posedge core_clk) begin
    if (restart) begin
      tsync_q <= 1'b0;
      bulk_q  <= 1'b0;
    end else begin
      if (take && is_sync) tsync_q <= 1'b1;
      if (take && is_bulk) bulk_q <= 1'b1;
    end
  end

  // two-entry buffer toward central control
  always_ff @(posedge core_clk) begin
    if (restart) begin
      bw_q <= 1'b0;
      br_q <= 1'b0;
      bc_q <= 2'h0;
    end else begin
      if (take && is_ord) bm_q[bw_q] <= rmsg_q;
      bw_q <= bw_q ^ (take && is_ord);
      br_q <= br_q ^ (ctrl_valid && ctrl_ready);
      bc_q <= bc_q + {1'b0, take && is_ord} - {1'b0, ctrl_valid && ctrl_ready};
    end
  end

  // ----------------------------------------------------------------
  // sender
  // ----------------------------------------------------------------
  // ordinary commands win over download messages
  always_comb begin
    new_msg = {`HS_AI_ORD, tx_cmd};
    kind    = hs_pkg::K_USER;
    want    = 1'b0;
    unique case (ph_q)
      hs_pkg::C_FLAG: want = 1'b0;
      hs_pkg::C_SYNC: begin
        new_msg = {`HS_AI_SYNC, `HS_CMD_SYNC};
        kind    = hs_pkg::K_SYNC;
        want    = 1'b1;
      end
      hs_pkg::C_DL: begin
        want = 1'b1;
        if (!tx_valid) begin
          new_msg = {`HS_AI_SYNC, dl_cmd};
          kind    = hs_pkg::K_DL;
        end
      end
      hs_pkg::C_RUN: want = tx_valid;
    endcase
  end

  assign start_new = frm && xs_q == hs_pkg::XS_IDLE && !pend_q && want &&
                     far.rxs == hs_pkg::RX_CTS && (kind == hs_pkg::K_SYNC || gap_q == 24'h0);
  assign tx_ready  = start_new && kind == hs_pkg::K_USER;
  assign acked     = frm && xs_q == hs_pkg::XS_REQ && far.rxs == hs_pkg::RX_POS;
  assign expired   = pend_q && kind_q != hs_pkg::K_SYNC && age_q == 24'(RETRY_CYC - 1);

  // handshake sender; retries restart from idle
  always_ff @(posedge core_clk) begin
    if (restart) begin
      xs_q   <= hs_pkg::XS_IDLE;
      xi_q   <= 2'h0;
      pend_q <= 1'b0;
      drop_q <= 1'b0;
    end else begin
      drop_q <= 1'b0;
      if (frm) begin
        unique case (xs_q)
          hs_pkg::XS_IDLE: if (pend_q && expired) begin
            pend_q <= 1'b0;
            drop_q <= 1'b1;
          end else if (pend_q ? far.rxs == hs_pkg::RX_CTS : start_new) begin
            xs_q   <= hs_pkg::XS_CHAR;
            xi_q   <= 2'h0;
            pend_q <= 1'b1;
          end
          hs_pkg::XS_CHAR: begin
            xi_q <= xi_q + 2'h1;
            if (xi_q == 2'h3) xs_q <= hs_pkg::XS_REQ;
          end
          hs_pkg::XS_REQ: if (far.rxs != hs_pkg::RX_CTS) begin
            xs_q <= hs_pkg::XS_IDLE;
            if (far.rxs == hs_pkg::RX_POS) pend_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // message hold, spacing and age counters
  always_ff @(posedge core_clk) begin
    if (restart) begin
      xmsg_q <= 16'h0;
      kind_q <= hs_pkg::K_USER;
      gap_q  <= 24'h0;
      age_q  <= 24'h0;
    end else begin
      if (start_new) begin
        xmsg_q <= new_msg;
        kind_q <= kind;
        age_q  <= 24'h0;
      end else if (age_q != 24'(RETRY_CYC - 1)) age_q <= age_q + 24'h1;
      if (start_new && kind != hs_pkg::K_SYNC) gap_q <= 24'(GAP_CYC - 1);
      else if (gap_q != 24'h0) gap_q <= gap_q - 24'h1;
    end
  end

  // ----------------------------------------------------------------
  // start-up phases
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (restart) begin
      ph_q   <= hs_pkg::C_FLAG;
      pk_q   <= 6'h0;
      dl_q   <= 4'h0;
      open_q <= 1'b0;
    end else begin
      unique case (ph_q)
        hs_pkg::C_FLAG: if (fl_q == 24'(FLAG_CYC - 1)) ph_q <= hs_pkg::C_SYNC;
        hs_pkg::C_SYNC: if (acked) begin
          pk_q <= pk_q + 6'h1;
          if (pk_q == `HS_SYNC_ACKS - 6'h1) ph_q <= hs_pkg::C_DL;
        end
        hs_pkg::C_DL: if ((acked || drop_q) && kind_q == hs_pkg::K_DL) begin
          dl_q <= dl_q + 4'h1;
          if (dl_q == 4'(DL_LEN - 1)) begin
            ph_q   <= hs_pkg::C_RUN;
            open_q <= 1'b1;
          end
        end
        hs_pkg::C_RUN: ph_q <= hs_pkg::C_RUN;
      endcase
    end
  end

  // outgoing byte
  always_ff @(posedge core_clk) begin
    if (restart) out_q <= '{txs: hs_pkg::TX_IDLE, rxs: hs_pkg::RX_CTS, nib: 4'h0};
    else out_q <= hs_pkg::make_byte(xs_q, rxs_q, xmsg_q, xi_q);
  end

  assign lk.frame     = frame_q;
  assign lk.card_byte = out_q;
  assign dl_idx       = dl_q;
  assign tx_drop      = drop_q;
  assign ctrl_msg     = bm_q[br_q];
  assign ctrl_valid   = bc_q != 2'h0;
  assign term_sync    = tsync_q;
  assign operational  = ph_q == hs_pkg::C_RUN && tsync_q && bulk_q;

endmodule

`default_nettype wire

/* File: rtl/hs_link_params.svh */
// constants for the handshake message link: timing, codes, counts
`ifndef HS_LINK_PARAMS_SVH
`define HS_LINK_PARAMS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define HS_CLK_MHZ        125
`define HS_MS_CYC(ms)     ((ms) * 1000 * `HS_CLK_MHZ)
`define HS_FRAME_MS       1
`define HS_FLAG_MS        128
`define HS_RETRY_MS       128
`define HS_TERM_GAP_MS    130
`define HS_CARD_GAP_MS    27
`define HS_FRAME_CYC      `HS_MS_CYC(`HS_FRAME_MS)
`define HS_FLAG_CYC       `HS_MS_CYC(`HS_FLAG_MS)
`define HS_RETRY_CYC      `HS_MS_CYC(`HS_RETRY_MS)
`define HS_TERM_GAP_CYC   `HS_MS_CYC(`HS_TERM_GAP_MS)
`define HS_CARD_GAP_CYC   `HS_MS_CYC(`HS_CARD_GAP_MS)

// ----------------------------------------------------------------
// message bytes and counts
// ----------------------------------------------------------------
`define HS_AI_SYNC        8'h80
`define HS_AI_ORD         8'h00
`define HS_CMD_SYNC       8'h24
`define HS_CMD_BULK_POS   8'h2e
`define HS_CMD_BULK_NEG   8'h2f
`define HS_NIBBLES        3'h4
`define HS_SYNC_ACKS      6'h20
`define HS_DL_LEN         4

`endif

/* File: rtl/hs_pkg.sv */
// types and helpers shared by both ends of the handshake message link
`default_nettype none

package hs_pkg;

  // ----------------------------------------------------------------
  // state codes carried in each handshake byte
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TX_IDLE    = 2'h0,
    TX_CHAR    = 2'h1,
    TX_REQ_ACK = 2'h2,
    TX_UNUSED  = 2'h3
  } tx_code_t;

  typedef enum logic [1:0] {
    RX_NEG = 2'h0,
    RX_POS = 2'h2,
    RX_CTS = 2'h3
  } rx_code_t;

  typedef struct packed {
    logic [1:0] txs;
    logic [1:0] rxs;
    logic [3:0] nib;
  } hs_byte_t;

  // sender state machine, same on both ends
  typedef enum logic [2:0] {
    XS_IDLE = 3'h1,
    XS_CHAR = 3'h2,
    XS_REQ  = 3'h4
  } xmit_t;

  typedef enum logic [3:0] {
    PH_WAIT = 4'h1,
    PH_SYNC = 4'h2,
    PH_BULK = 4'h4,
    PH_OP   = 4'h8
  } term_phase_t;

  typedef enum logic [3:0] {
    C_FLAG = 4'h1,
    C_SYNC = 4'h2,
    C_DL   = 4'h4,
    C_RUN  = 4'h8
  } card_phase_t;

  typedef enum logic [2:0] {
    K_USER = 3'h1,
    K_SYNC = 3'h2,
    K_DL   = 3'h4
  } msg_kind_t;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // modulo-16 sum of the four message nibbles
  function automatic logic [3:0] cksum(input logic [15:0] m);
    return m[15:12] + m[11:8] + m[7:4] + m[3:0];
  endfunction

  // nibble i of a message, address first
  function automatic logic [3:0] nib_at(input logic [15:0] m, input logic [1:0] i);
    return 4'(m >> {~i, 2'b00});
  endfunction

  // outgoing byte from sender state and receiver state
  function automatic hs_byte_t make_byte(input xmit_t s, input logic [1:0] rx,
                                         input logic [15:0] m, input logic [1:0] i);
    hs_byte_t b;
    b.rxs = rx;
    b.txs = TX_IDLE;
    b.nib = 4'h0;
    if (s == XS_CHAR) begin
      b.txs = TX_CHAR;
      b.nib = nib_at(m, i);
    end else if (s == XS_REQ) begin
      b.txs = TX_REQ_ACK;
      b.nib = cksum(m);
    end
    return b;
  endfunction

endpackage

`default_nettype wire

/* File: rtl/handshake_link_if.sv */
// link between line card and terminal: frame strobe, handshake bytes, sync flag
`timescale 1ns/1ns
`default_nettype none

interface handshake_link_if;
  logic             frame;
  hs_pkg::hs_byte_t card_byte;
  hs_pkg::hs_byte_t term_byte;
  logic             term_flag;

  modport card (output frame, output card_byte, input term_byte, input term_flag);
  modport term (input frame, input card_byte, output term_byte, output term_flag);
endinterface

`default_nettype wire

/* File: rtl/subscriber_terminal.sv */
// terminal end of the handshake message link
`timescale 1ns/1ns
`default_nettype none
`include "hs_link_params.svh"

module subscriber_terminal #(
  parameter int GAP_CYC = `HS_TERM_GAP_CYC
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // loop
  input  wire logic        link_up,
  handshake_link_if.term   lk,
  // messages toward the line card
  input  wire logic [15:0] tx_msg,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  // messages from the line card
  output logic [15:0]      rx_msg,
  output logic             rx_valid,
  input  wire logic        rx_ready,
  // options and status
  input  wire logic        bulk_pos_en,
  output logic             sync_on,
  output logic             link_ready
);

  hs_pkg::term_phase_t ph_q;
  hs_pkg::xmit_t       xs_q;
  hs_pkg::hs_byte_t    far, out_q;
  logic        restart, frm, flag_q, sync_q, csync_q, dl_q;
  logic [23:0] gap_q;
  logic [1:0]  rxs_q, xi_q, bc_q;
  logic [2:0]  rcnt_q;
  logic [15:0] rmsg_q, xmsg_q, new_msg;
  logic [15:0] bm_q [2];
  logic        bw_q, br_q, pend_q, want, start_new, acked;
  logic        good, ai_sync, is_sync, is_dl, is_ord, room, take, push;

  assign restart = srst | ~link_up;
  assign frm     = lk.frame & ~restart;
  assign far     = lk.card_byte;

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  // message class from address and info byte
  assign ai_sync = rmsg_q[15:8] == `HS_AI_SYNC;
  assign is_sync = ai_sync && rmsg_q[7:0] == `HS_CMD_SYNC;
  assign is_dl   = ai_sync && !is_sync;
  assign is_ord  = !ai_sync;

  // not ready only when an ordinary message meets a full buffer
  assign room = !(is_ord && ph_q == hs_pkg::PH_OP && bc_q == 2'h2);
  assign good = rcnt_q == `HS_NIBBLES && hs_pkg::cksum(rmsg_q) == far.nib;
  assign take = frm && far.txs == hs_pkg::TX_REQ_ACK && rxs_q == hs_pkg::RX_CTS &&
                good && room;
  assign push = take && is_ord && ph_q == hs_pkg::PH_OP;

  // receive state: clear-to-send while nibbles arrive
  always_ff @(posedge core_clk) begin
    if (restart) begin
      rxs_q  <= hs_pkg::RX_CTS;
      rcnt_q <= 3'h0;
    end else if (frm) begin
      unique case (far.txs)
        hs_pkg::TX_IDLE: begin
          rxs_q  <= hs_pkg::RX_CTS;
          rcnt_q <= 3'h0;
        end
        hs_pkg::TX_CHAR: if (rxs_q == hs_pkg::RX_CTS) begin
          if (rcnt_q == `HS_NIBBLES) rxs_q <= hs_pkg::RX_NEG;
          else rcnt_q <= rcnt_q + 3'h1;
        end
        hs_pkg::TX_REQ_ACK: if (rxs_q == hs_pkg::RX_CTS) begin
          // a well-formed message is taken if there is room, known command or not
          rxs_q <= (good && room) ? hs_pkg::RX_POS : hs_pkg::RX_NEG;
        end
        default: rxs_q <= hs_pkg::RX_NEG;
      endcase
    end
  end

  // nibble assembly, address nibble first
  always_ff @(posedge core_clk) begin
    if (restart) rmsg_q <= 16'h0;
    else if (frm && far.txs == hs_pkg::TX_CHAR && rxs_q == hs_pkg::RX_CTS &&
             rcnt_q != `HS_NIBBLES) rmsg_q <= {rmsg_q[11:0], far.nib};
  end

  // start-up events seen from the card; download content is dropped
  always_ff @(posedge core_clk) begin
    if (restart) begin
      csync_q <= 1'b0;
      dl_q    <= 1'b0;
    end else begin
      if (take && is_sync) csync_q <= 1'b1;
      if (take && is_dl) dl_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // receive buffer
  // ----------------------------------------------------------------
  // two entries so a user stall loses nothing; full shows as refusal
  always_ff @(posedge core_clk) begin
    if (restart) begin
      bw_q <= 1'b0;
      br_q <= 1'b0;
      bc_q <= 2'h0;
    end else begin
      if (push) bm_q[bw_q] <= rmsg_q;
      bw_q <= bw_q ^ push;
      br_q <= br_q ^ (rx_valid && rx_ready);
      bc_q <= bc_q + {1'b0, push} - {1'b0, rx_valid && rx_ready};
    end
  end

  // ----------------------------------------------------------------
  // sender
  // ----------------------------------------------------------------
  // message source follows the start-up phase
  always_comb begin
    new_msg = tx_msg;
    want    = 1'b0;
    unique case (ph_q)
      hs_pkg::PH_WAIT: want = 1'b0;
      hs_pkg::PH_SYNC: begin
        new_msg = {`HS_AI_SYNC, `HS_CMD_SYNC};
        want    = 1'b1;
      end
      hs_pkg::PH_BULK: begin
        new_msg = {`HS_AI_SYNC, bulk_pos_en ? `HS_CMD_BULK_POS : `HS_CMD_BULK_NEG};
        want    = dl_q;
      end
      hs_pkg::PH_OP: want = tx_valid;
    endcase
  end

  // a new message only after the spacing has run out
  assign start_new = frm && xs_q == hs_pkg::XS_IDLE && !pend_q && want &&
                     far.rxs == hs_pkg::RX_CTS && gap_q == 24'h0;
  assign tx_ready  = start_new && ph_q == hs_pkg::PH_OP;
  assign acked     = frm && xs_q == hs_pkg::XS_REQ && far.rxs == hs_pkg::RX_POS;

  // idle, four characters, request-acknowledge, back to idle
  always_ff @(posedge core_clk) begin
    if (restart) begin
      xs_q   <= hs_pkg::XS_IDLE;
      xi_q   <= 2'h0;
      pend_q <= 1'b0;
    end else if (frm) begin
      unique case (xs_q)
        hs_pkg::XS_IDLE: if (pend_q ? far.rxs == hs_pkg::RX_CTS : start_new) begin
          xs_q   <= hs_pkg::XS_CHAR;
          xi_q   <= 2'h0;
          pend_q <= 1'b1;
        end
        hs_pkg::XS_CHAR: begin
          xi_q <= xi_q + 2'h1;
          if (xi_q == 2'h3) xs_q <= hs_pkg::XS_REQ;
        end
        hs_pkg::XS_REQ: if (far.rxs != hs_pkg::RX_CTS) begin
          xs_q <= hs_pkg::XS_IDLE;
          if (far.rxs == hs_pkg::RX_POS) pend_q <= 1'b0;
        end
      endcase
    end
  end

  // held message and spacing counter
  always_ff @(posedge core_clk) begin
    if (restart) begin
      xmsg_q <= 16'h0;
      gap_q  <= 24'h0;
    end else begin
      if (start_new) xmsg_q <= new_msg;
      if (start_new) gap_q <= 24'(GAP_CYC - 1);
      else if (gap_q != 24'h0) gap_q <= gap_q - 24'h1;
    end
  end

  // ----------------------------------------------------------------
  // start-up phases
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (restart) begin
      ph_q   <= hs_pkg::PH_WAIT;
      sync_q <= 1'b0;
    end else begin
      unique case (ph_q)
        hs_pkg::PH_WAIT: if (csync_q) ph_q <= hs_pkg::PH_SYNC;
        hs_pkg::PH_SYNC: if (acked) begin
          ph_q   <= hs_pkg::PH_BULK;
          sync_q <= 1'b1;
        end
        hs_pkg::PH_BULK: if (acked) ph_q <= hs_pkg::PH_OP;
        hs_pkg::PH_OP: ph_q <= hs_pkg::PH_OP;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // link outputs
  // ----------------------------------------------------------------
  // code 11 cannot arise: the sender only maps its three states
  always_ff @(posedge core_clk) begin
    if (restart) begin
      out_q  <= '{txs: hs_pkg::TX_IDLE, rxs: hs_pkg::RX_CTS, nib: 4'h0};
      flag_q <= 1'b0;
    end else begin
      out_q  <= hs_pkg::make_byte(xs_q, rxs_q, xmsg_q, xi_q);
      flag_q <= 1'b1;
    end
  end

  assign lk.term_byte = out_q;
  assign lk.term_flag = flag_q;
  assign rx_msg       = bm_q[br_q];
  assign rx_valid     = bc_q != 2'h0;
  assign sync_on      = sync_q;
  assign link_ready   = ph_q == hs_pkg::PH_OP;

endmodule

`default_nettype wire

/* File: testbench/hs_link_sva.sv */
// concurrent checks on the signals between line card and terminal
`timescale 1ns/1ns
`default_nettype none

module hs_link_sva #(
  parameter int FRAME_CYC = 40,
  parameter int FLAG_CYC  = 400
) (
  // clock and reset
  input wire logic             core_clk,
  input wire logic             srst,
  // link
  input wire logic             frame,
  input wire hs_pkg::hs_byte_t card_byte,
  input wire hs_pkg::hs_byte_t term_byte,
  input wire logic             term_flag
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  logic [15:0] up_q;
  logic [3:0]  sum_q;
  logic        fr_q;

  // cycles since restart and running nibble sum of the card sender
  always_ff @(posedge core_clk) begin
    fr_q <= frame;
    if (srst) begin
      up_q  <= 16'h0;
      sum_q <= 4'h0;
    end else begin
      if (up_q != 16'hffff) up_q <= up_q + 16'h1;
      if (card_byte.txs == 2'h0) sum_q <= 4'h0;
      else if (fr_q && card_byte.txs == 2'h1) sum_q <= sum_q + card_byte.nib;
    end
  end

  // a state code newly taken up
  sequence new_code(t, c);
    t == c && $past(t) != c;
  endsequence

  frame_period_a: assert property (frame |-> ##FRAME_CYC frame)
    else $error("frame spacing wrong");
  byte_hold_a: assert property (!$past(frame, 2) |-> $stable(card_byte) && $stable(term_byte))
    else $error("byte changed off frame");
  no_code11_a: assert property (term_byte.txs != 2'h3)
    else $error("terminal sent unused code");
  req_order_a: assert property (new_code(term_byte.txs, 2'h2) |-> $past(term_byte.txs) == 2'h1)
    else $error("request without characters");
  card_ack_a: assert property (new_code(card_byte.rxs, 2'h2) |-> $past(term_byte.txs) == 2'h2)
    else $error("card ack without request");
  term_ack_a: assert property (new_code(term_byte.rxs, 2'h2) |-> $past(card_byte.txs) == 2'h2)
    else $error("terminal ack without request");
  negative_acknowledge_exit_a: assert property ($past(card_byte.rxs) == 2'h0 && card_byte.rxs == 2'h3
    |-> $past(term_byte.txs) == 2'h0)
    else $error("refusal left without idle");
  cksum_ok_a: assert property (card_byte.txs == 2'h2 |-> card_byte.nib == sum_q)
    else $error("checksum wrong");
  flag_watch_a: assert property (card_byte.txs != 2'h0 |-> term_flag && up_q >= FLAG_CYC)
    else $error("card sent before flag watch");
endmodule

`default_nettype wire

/* File: testbench/test_handshake_message_sync_link.sv */
// self-checking bench: both link ends joined through the interface
`timescale 1ns/1ns
`default_nettype none

module test_handshake_message_sync_link;
  logic core_clk = 1'b0, srst = 1'b1, link_up = 1'b1, bulk_pos_en = 1'b1;
  logic [7:0] c_cmd = 8'h0, dl_cmd;
  logic [3:0] dl_idx;
  logic [15:0] ctrl_msg, t_msg = 16'h0, rx_msg;
  logic c_valid = 1'b0, ctrl_ready = 1'b0, t_valid = 1'b0, rx_ready = 1'b0;
  logic c_ready, c_drop, ctrl_valid, term_sync, operational, t_ready, rx_valid, sync_on, link_ready;
  int n_fail = 0, checked = 0, cyc = 0;

  handshake_link_if lk ();
  assign dl_cmd = {4'h3, dl_idx};

  switch_line_card #(.FRAME_CYC(40), .FLAG_CYC(400), .GAP_CYC(100), .RETRY_CYC(300))
    i_switch_line_card (.core_clk, .srst, .link_up, .lk(lk), .tx_cmd(c_cmd), .tx_valid(c_valid),
    .tx_ready(c_ready), .tx_drop(c_drop), .dl_idx, .dl_cmd, .ctrl_msg, .ctrl_valid, .ctrl_ready,
    .term_sync, .operational);
  subscriber_terminal #(.GAP_CYC(100)) i_subscriber_terminal (.core_clk, .srst, .link_up,
    .lk(lk), .tx_msg(t_msg), .tx_valid(t_valid), .tx_ready(t_ready), .rx_msg, .rx_valid,
    .rx_ready, .bulk_pos_en, .sync_on, .link_ready);
  hs_link_sva i_hs_link_sva (.core_clk,
    .srst(srst || !link_up), .frame(lk.frame), .card_byte(lk.card_byte),
    .term_byte(lk.term_byte), .term_flag(lk.term_flag));

  // clock and hang limit
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      complete_run;
    end
  end

  task chk(input logic [15:0] seen, exp, input string m);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  task complete_run;
    $display("checked %0d failed %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task send_c(input logic [7:0] c);
    c_cmd <= c;
    c_valid <= 1'b1;
    do @(posedge core_clk); while (c_ready !== 1'b1);
  endtask

  task send_t(input logic [15:0] m);
    t_msg <= m;
    t_valid <= 1'b1;
    do @(posedge core_clk); while (t_ready !== 1'b1);
  endtask

  // start-up to operation with the chosen download answer
  task t_startup(input logic pos);
    bulk_pos_en <= pos;
    for (int i = 0; i < 30000 && !(operational && link_ready); i++) @(posedge core_clk);
    chk(term_sync, 1, "card saw terminal sync");
    chk(sync_on, 1, "terminal sync indicator");
    chk(operational, 1, "card operational");
    chk(link_ready, 1, "terminal operational");
    chk(dl_idx, 4'h4, "download sent once in full");
    $display("startup done");
  endtask

  // card to terminal with receiver stalled: third refused then dropped
  task t_down;
    rx_ready <= 1'b0;
    for (int k = 0; k < 3; k++) send_c(8'ha1 + 8'(k));
    c_valid <= 1'b0;
    for (int i = 0; i < 400 && c_drop !== 1'b1; i++) @(posedge core_clk);
    chk(c_drop, 1, "unacked command dropped");
    rx_ready <= 1'b1;
    @(posedge core_clk);
    chk(rx_msg, 16'h00a1, "first word");
    @(posedge core_clk);
    chk(rx_msg, 16'h00a2, "second word");
    @(posedge core_clk);
    chk(rx_valid, 0, "third refused, not kept");
    $display("card to terminal done");
  endtask

  // terminal to card with central side stalled: refusal then retry
  task t_up;
    send_t(16'h3a5c);
    send_t(16'h0f71);
    send_t(16'h1111);
    t_valid <= 1'b0;
    for (int i = 0; i < 400 && lk.card_byte.rxs !== 2'h0; i++) @(posedge core_clk);
    chk(lk.card_byte.rxs, 0, "card refuses when full");
    ctrl_ready <= 1'b1;
    @(posedge core_clk);
    chk(ctrl_msg, 16'h3a5c, "first word");
    @(posedge core_clk);
    chk(ctrl_msg, 16'h0f71, "second word");
    @(posedge core_clk);
    for (int i = 0; i < 800 && ctrl_valid !== 1'b1; i++) @(posedge core_clk);
    chk(ctrl_valid, 1, "retried word arrives");
    chk(ctrl_msg, 16'h1111, "retried word");
    $display("terminal to card done");
  endtask

  // loop loss restarts sync; second start uses the negative answer
  task t_reset;
    link_up <= 1'b0;
    repeat (3) @(posedge core_clk);
    link_up <= 1'b1;
    @(posedge core_clk);
    chk(operational, 0, "card restarted");
    chk(sync_on, 0, "terminal restarted");
    t_startup(1'b0);
  endtask

  initial begin
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    t_startup(1'b1);
    t_down;
    t_up;
    t_reset;
    complete_run;
  end
endmodule

`default_nettype wire
